// ==== include/alu_pkg.sv ====
// Constants, types and helper functions shared by the arithmetic and flag datapath.
// How it works
// - Add-with-carry writes destination plus source plus carry; updates N, Z, V, C.
// - Subtract-with-borrow writes destination minus source minus carry; updates N, Z, V, C.
// - Decimal add on bytes sums packed digits plus carry; only Z and C change.
// - Decimal subtract on bytes removes source and carry; only Z and C change.
// - Unsigned multiply, byte or word, writes the product; N, Z set, V, C cleared.
// - Unsigned divide, 16 by 8 or 32 by 16; V updated, N and Z only without overflow, C cleared.
// - Quick add of plus or minus one or two, byte or word; all flags updated.
// - Address add and subtract work on the whole word and keep every flag.
// - Compare subtracts source from destination, discards it, updates the four flags.
// - Frame move uses frame pointer plus signed byte offset; N, Z set, V cleared.
// - Any flag an operation does not touch keeps its previous value.
package alu_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_DST    = 8'h04;
  localparam logic [7:0] OFF_DST_HI = 8'h08;
  localparam logic [7:0] OFF_SRC    = 8'h0C;
  localparam logic [7:0] OFF_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_FP     = 8'h14;
  localparam logic [7:0] OFF_ADDR   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam int unsigned CMD_SIZE_BIT = 4;
  localparam int unsigned CMD_IMM_LSB  = 8;
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_N = 3;
  localparam logic SIZE_WORD = 1'b1;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  localparam logic [5:0]  DIV_STEPS = 6'h20;
  localparam logic [4:0]  BCD_MAX   = 5'h09;
  localparam logic [4:0]  BCD_ADJ   = 5'h06;

  typedef enum logic [3:0] {
    OP_ADD_WITH_CARRY       = 4'b0000,
    OP_SUBTRACT_WITH_BORROW = 4'b0001,
    OP_DECIMAL_ADD          = 4'b0010,
    OP_DECIMAL_SUBTRACT     = 4'b0011,
    OP_UNSIGNED_MULTIPLY    = 4'b0100,
    OP_UNSIGNED_DIVIDE      = 4'b0101,
    OP_QUICK_ADD            = 4'b0110,
    OP_ADDRESS_ADD          = 4'b0111,
    OP_ADDRESS_SUBTRACT     = 4'b1000,
    OP_COMPARE_OP           = 4'b1001,
    OP_FRAME_RELATIVE_MOVE  = 4'b1010
  } op_e;

  typedef enum logic {ST_IDLE = 1'b0, ST_DIV = 1'b1} state_e;

  typedef struct packed {
    logic [15:0] res;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
  } arith_s;

  // Sign bit of a value at the given operand size.
  function automatic logic msb_of(input logic [15:0] v, input logic size);
    return (size == SIZE_WORD) ? v[15] : v[7];
  endfunction : msb_of

  function automatic logic zero_of(input logic [15:0] v, input logic size);
    return (size == SIZE_WORD) ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endfunction : zero_of

  // Binary add or subtract with carry in; a byte operation keeps the upper byte.
  function automatic arith_s add_sub(input logic [15:0] a, input logic [15:0] b,
                                     input logic ci, input logic sub, input logic size);
    arith_s      r;
    logic [16:0] w;
    logic [8:0]  y;
    logic        am;
    w = sub ? 17'({1'b0, a} - {1'b0, b} - {16'h0000, ci})
            : 17'({1'b0, a} + {1'b0, b} + {16'h0000, ci});
    y = sub ? 9'({1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, ci})
            : 9'({1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, ci});
    r.res = (size == SIZE_WORD) ? w[15:0] : {a[15:8], y[7:0]};
    r.c   = (size == SIZE_WORD) ? w[16] : y[8];
    am    = msb_of(a, size);
    r.n   = msb_of(r.res, size);
    r.z   = zero_of(r.res, size);
    r.v   = (sub ? (am != msb_of(b, size)) : (am == msb_of(b, size))) && (r.n != am);
    return r;
  endfunction : add_sub

  // Packed decimal byte add or subtract; bit 8 is the decimal carry or borrow.
  function automatic logic [8:0] bcd_op(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci, input logic sub);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       c1;
    logic       c2;
    if (sub) begin
      lo = 5'({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci});
      c1 = lo[4];
      if (c1) lo = 5'(lo - BCD_ADJ);
      hi = 5'({1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, c1});
      c2 = hi[4];
      if (c2) hi = 5'(hi - BCD_ADJ);
    end else begin
      lo = 5'({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci});
      c1 = lo > BCD_MAX;
      if (c1) lo = 5'(lo + BCD_ADJ);
      hi = 5'({1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c1});
      c2 = hi > BCD_MAX;
      if (c2) hi = 5'(hi + BCD_ADJ);
    end
    return {c2, hi[3:0], lo[3:0]};
  endfunction : bcd_op

  // Quick immediate code: 0 is +1, 1 is +2, 2 is -1, 3 is -2.
  function automatic logic [15:0] quick_val(input logic [1:0] code);
    logic [15:0] mag;
    mag = code[0] ? 16'h0002 : 16'h0001;
    return code[1] ? 16'(16'h0000 - mag) : mag;
  endfunction : quick_val
endpackage : alu_pkg

// ==== include/div_if.sv ====
// Start and result bundle between the datapath and its iterative divider.
`timescale 1ns/10ps
interface div_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        done;
  logic [31:0] quotient;
  logic [15:0] remainder;
  modport requester (output start, dividend, divisor, input done, quotient, remainder);
  modport worker (input start, dividend, divisor, output done, quotient, remainder);
endinterface : div_if

// ==== hw/div_unit.sv ====
// Restoring unsigned divider, one quotient bit per clock.
`timescale 1ns/10ps
module div_unit (
  input  wire logic clock, // System clock.
  input  wire logic rst,   // Asynchronous reset, active high.
  div_if.worker     di     // Start, operands and results.
);
  import alu_pkg::*;

  logic [16:0] rem_r;
  logic [31:0] quo_r;
  logic [15:0] dvs_r;
  logic [31:0] dvd_r;
  logic [5:0]  cnt_r;
  logic        run_r;
  logic        done_r;
  logic [16:0] shifted;
  logic        fits;

  // Trial subtraction of the divisor from the shifted partial remainder.
  always_comb begin
    shifted = {rem_r[15:0], quo_r[31]};
    fits    = shifted >= {1'b0, dvs_r};
  end

  // A start while running restarts; the datapath never does that.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rem_r <= 17'h00000;
      quo_r <= 32'h00000000;
      dvs_r <= 16'h0000;
      dvd_r <= 32'h00000000;
      cnt_r <= 6'h00;
      run_r <= 1'b0;
    end else if (di.start) begin
      rem_r <= 17'h00000;
      quo_r <= di.dividend;
      dvs_r <= di.divisor;
      dvd_r <= di.dividend;
      cnt_r <= 6'h00;
      run_r <= 1'b1;
    end else if (run_r) begin
      rem_r <= fits ? 17'(shifted - {1'b0, dvs_r}) : shifted;
      quo_r <= {quo_r[30:0], fits};
      cnt_r <= 6'(cnt_r + 6'h01);
      if (cnt_r == 6'(DIV_STEPS - 6'h01)) run_r <= 1'b0;
    end
  end

  // Completion pulse, one cycle after the last step.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) done_r <= 1'b0;
    else     done_r <= run_r && (cnt_r == 6'(DIV_STEPS - 6'h01));
  end

  assign di.done      = done_r;
  assign di.quotient  = quo_r;
  assign di.remainder = rem_r[15:0];

  a_div_latency: assert property (@(posedge clock) disable iff (rst)
    di.start |-> !di.done [*8] ##26 di.done)
    else $error("divider did not finish 33 cycles after start");
  a_div_identity: assert property (@(posedge clock) disable iff (rst)
    di.done |-> (64'(di.quotient) * 64'(dvs_r) + 64'(di.remainder) == 64'(dvd_r))
                && (di.remainder < dvs_r))
    else $error("divider result does not reproduce the dividend");
endmodule : div_unit

// ==== hw/cpu_arith_flag_datapath.sv ====
// Arithmetic, decimal, multiply, divide, compare and frame-move result path with flags.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module cpu_arith_flag_datapath (
  input  wire logic                        clock,      // 200 MHz clock.
  input  wire logic                        rst,        // Async reset, high.
  input  wire logic [alu_pkg::ADDR_W-1:0]  addr,       // Register byte address.
  input  wire logic [alu_pkg::DATA_W-1:0]  wr_data,    // Write data.
  input  wire logic                        wr_en,      // Write strobe.
  input  wire logic                        rd_en,      // Read strobe.
  output logic      [alu_pkg::DATA_W-1:0]  rd_data,    // Read data, next cycle.
  output logic      [3:0]                  flags,      // N Z V C.
  output logic      [alu_pkg::DATA_W-1:0]  frame_addr, // Frame move address.
  output logic                             busy        // Divide in progress.
);
  import alu_pkg::*;

  state_e      state_r;
  logic        busy_r;
  logic [15:0] dst_r;
  logic [15:0] dst_hi_r;
  logic [15:0] src_r;
  logic [15:0] fp_r;
  logic [15:0] addr_r;
  logic [15:0] cmd_r;
  logic [3:0]  flags_r;
  logic [15:0] rd_data_r;
  logic        div_size_r;

  // Decoded command write.
  logic        exec;
  logic        bus_wr;
  op_e         op_in;
  logic        size_in;
  logic [7:0]  imm_in;

  // Candidate results.
  arith_s      r_add_with_carry;
  arith_s      r_subtract_with_borrow;
  arith_s      r_quick;
  arith_s      r_cmp;
  logic [8:0]  r_bcd;
  logic [31:0] r_prod;
  logic [15:0] ext_src;
  logic [15:0] ext_disp;
  logic        div_zero;
  logic        div_ovf;

  // Next values.
  logic [15:0] dst_nxt;
  logic [15:0] dst_hi_nxt;
  logic [3:0]  flags_nxt;
  logic [15:0] addr_nxt;
  logic        dst_we;
  logic        hi_we;
  logic        flags_we;
  logic        addr_we;

  div_if di ();

  div_unit u_div (
    .clock (clock),
    .rst   (rst),
    .di    (di.worker)
  );

  // A command is taken only when no divide runs; a write while busy is dropped.
  always_comb begin
    bus_wr  = wr_en && (state_r == ST_IDLE);
    exec    = bus_wr && (addr == OFF_CMD);
    op_in   = op_e'(wr_data[3:0]);
    size_in = wr_data[CMD_SIZE_BIT];
    imm_in  = wr_data[CMD_IMM_LSB +: 8];
  end

  // All candidate results are formed in parallel from the current registers.
  always_comb begin
    r_add_with_carry   = add_sub(dst_r, src_r, flags_r[FLAG_C], 1'b0, size_in);
    r_subtract_with_borrow   = add_sub(dst_r, src_r, flags_r[FLAG_C], 1'b1, size_in);
    r_quick  = add_sub(dst_r, quick_val(imm_in[1:0]), 1'b0, 1'b0, size_in);
    r_cmp    = add_sub(dst_r, src_r, 1'b0, 1'b1, size_in);
    r_bcd    = bcd_op(dst_r[7:0], src_r[7:0], flags_r[FLAG_C],
                      op_in == OP_DECIMAL_SUBTRACT);
    r_prod   = (size_in == SIZE_WORD) ? 32'(dst_r) * 32'(src_r)
                                      : {16'h0000, 16'(dst_r[7:0]) * 16'(src_r[7:0])};
    ext_src  = (size_in == SIZE_WORD) ? src_r : {{8{src_r[7]}}, src_r[7:0]};
    ext_disp = {{8{imm_in[7]}}, imm_in};
    div_zero = (size_in == SIZE_WORD) ? (src_r == 16'h0000) : (src_r[7:0] == 8'h00);
    div_ovf  = (div_size_r == SIZE_WORD) ? (di.quotient[31:16] != 16'h0000)
                                         : (di.quotient[31:8] != 24'h000000);
  end

  // Divider operands: word mode divides the register pair, byte mode one word.
  always_comb begin
    di.start    = exec && (op_in == OP_UNSIGNED_DIVIDE) && !div_zero;
    di.dividend = (size_in == SIZE_WORD) ? {dst_hi_r, dst_r} : {16'h0000, dst_r};
    di.divisor  = (size_in == SIZE_WORD) ? src_r : {8'h00, src_r[7:0]};
  end

  // Operation select; flags start from their old value so untouched ones hold.
  always_comb begin
    dst_nxt    = dst_r;
    dst_hi_nxt = dst_hi_r;
    flags_nxt  = flags_r;
    addr_nxt   = addr_r;
    dst_we     = 1'b0;
    hi_we      = 1'b0;
    flags_we   = 1'b0;
    addr_we    = 1'b0;
    if (state_r == ST_DIV && di.done) begin
      flags_we          = 1'b1;
      flags_nxt[FLAG_V] = div_ovf;
      flags_nxt[FLAG_C] = 1'b0;
      if (!div_ovf) begin
        flags_nxt[FLAG_N] = (div_size_r == SIZE_WORD) ? di.quotient[15] : di.quotient[7];
        flags_nxt[FLAG_Z] = zero_of(di.quotient[15:0], div_size_r);
        dst_we            = 1'b1;
        if (div_size_r == SIZE_WORD) begin
          dst_nxt    = di.quotient[15:0];
          dst_hi_nxt = di.remainder;
          hi_we      = 1'b1;
        end else begin
          dst_nxt = {di.remainder[7:0], di.quotient[7:0]};
        end
      end
    end else if (exec) begin
      unique case (op_in)
        OP_ADD_WITH_CARRY: begin
          dst_we    = 1'b1;
          flags_we  = 1'b1;
          dst_nxt   = r_add_with_carry.res;
          flags_nxt = {r_add_with_carry.n, r_add_with_carry.z, r_add_with_carry.v, r_add_with_carry.c};
        end
        OP_SUBTRACT_WITH_BORROW: begin
          dst_we    = 1'b1;
          flags_we  = 1'b1;
          dst_nxt   = r_subtract_with_borrow.res;
          flags_nxt = {r_subtract_with_borrow.n, r_subtract_with_borrow.z, r_subtract_with_borrow.v, r_subtract_with_borrow.c};
        end
        OP_DECIMAL_ADD, OP_DECIMAL_SUBTRACT: begin
          // Byte only whatever the size bit says; N and V are left alone.
          dst_we            = 1'b1;
          flags_we          = 1'b1;
          dst_nxt           = {dst_r[15:8], r_bcd[7:0]};
          flags_nxt[FLAG_Z] = (r_bcd[7:0] == 8'h00);
          flags_nxt[FLAG_C] = r_bcd[8];
        end
        OP_UNSIGNED_MULTIPLY: begin
          dst_we            = 1'b1;
          flags_we          = 1'b1;
          dst_nxt           = r_prod[15:0];
          hi_we             = (size_in == SIZE_WORD);
          dst_hi_nxt        = r_prod[31:16];
          flags_nxt[FLAG_N] = (size_in == SIZE_WORD) ? r_prod[31] : r_prod[15];
          flags_nxt[FLAG_Z] = (r_prod == 32'h00000000);
          flags_nxt[FLAG_V] = 1'b0;
          flags_nxt[FLAG_C] = 1'b0;
        end
        OP_UNSIGNED_DIVIDE: begin
          // A zero divisor is an overflow at once; the register is kept.
          if (div_zero) begin
            flags_we          = 1'b1;
            flags_nxt[FLAG_V] = 1'b1;
            flags_nxt[FLAG_C] = 1'b0;
          end
        end
        OP_QUICK_ADD: begin
          dst_we    = 1'b1;
          flags_we  = 1'b1;
          dst_nxt   = r_quick.res;
          flags_nxt = {r_quick.n, r_quick.z, r_quick.v, r_quick.c};
        end
        OP_ADDRESS_ADD: begin
          dst_we  = 1'b1;
          dst_nxt = 16'(dst_r + ext_src);
        end
        OP_ADDRESS_SUBTRACT: begin
          dst_we  = 1'b1;
          dst_nxt = 16'(dst_r - ext_src);
        end
        OP_COMPARE_OP: begin
          flags_we  = 1'b1;
          flags_nxt = {r_cmp.n, r_cmp.z, r_cmp.v, r_cmp.c};
        end
        OP_FRAME_RELATIVE_MOVE: begin
          // The moved datum is taken from the source register.
          dst_we            = 1'b1;
          flags_we          = 1'b1;
          addr_we           = 1'b1;
          addr_nxt          = 16'(fp_r + ext_disp);
          dst_nxt           = (size_in == SIZE_WORD) ? src_r : {dst_r[15:8], src_r[7:0]};
          flags_nxt[FLAG_N] = msb_of(src_r, size_in);
          flags_nxt[FLAG_Z] = zero_of(src_r, size_in);
          flags_nxt[FLAG_V] = 1'b0;
        end
        default: begin
          // Unused op codes do nothing.
          dst_we = 1'b0;
        end
      endcase
    end
  end

  // Destination pair: operation results take priority over software writes.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dst_r    <= RST_WORD;
      dst_hi_r <= RST_WORD;
    end else begin
      if (dst_we) dst_r <= dst_nxt;
      else if (bus_wr && addr == OFF_DST) dst_r <= wr_data;
      if (hi_we) dst_hi_r <= dst_hi_nxt;
      else if (bus_wr && addr == OFF_DST_HI) dst_hi_r <= wr_data;
    end
  end

  // Condition flags, also writable so software can preset carry.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) flags_r <= RST_FLAGS;
    else if (flags_we) flags_r <= flags_nxt;
    else if (bus_wr && addr == OFF_FLAGS) flags_r <= wr_data[3:0];
  end

  // Operand, frame pointer, command and address registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_r  <= RST_WORD;
      fp_r   <= RST_WORD;
      cmd_r  <= RST_WORD;
      addr_r <= RST_WORD;
    end else begin
      if (bus_wr && addr == OFF_SRC) src_r <= wr_data;
      if (bus_wr && addr == OFF_FP) fp_r <= wr_data;
      if (exec) cmd_r <= wr_data;
      if (addr_we) addr_r <= addr_nxt;
    end
  end

  // Divide sequencing; busy is kept as its own flop so the port is registered.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      busy_r     <= 1'b0;
      div_size_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (di.start) begin
            state_r    <= ST_DIV;
            busy_r     <= 1'b1;
            div_size_r <= size_in;
          end
        end
        ST_DIV: begin
          if (di.done) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_r <= RST_WORD;
    end else if (rd_en) begin
      unique case (addr)
        OFF_CMD:    rd_data_r <= cmd_r;
        OFF_DST:    rd_data_r <= dst_r;
        OFF_DST_HI: rd_data_r <= dst_hi_r;
        OFF_SRC:    rd_data_r <= src_r;
        OFF_FLAGS:  rd_data_r <= {12'h000, flags_r};
        OFF_FP:     rd_data_r <= fp_r;
        OFF_ADDR:   rd_data_r <= addr_r;
        OFF_STATUS: rd_data_r <= {15'h0000, busy_r};
        default:    rd_data_r <= RST_WORD;
      endcase
    end else begin
      rd_data_r <= RST_WORD;
    end
  end

  assign rd_data    = rd_data_r;
  assign flags      = flags_r;
  assign frame_addr = addr_r;
  assign busy       = busy_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_add_with_carry_word_sum: assert property (
    exec && op_in == OP_ADD_WITH_CARRY && size_in == SIZE_WORD
    |=> dst_r == $past(16'(dst_r + src_r + {15'h0000, flags_r[FLAG_C]})))
    else $error("add with carry wrote a wrong sum");
  a_subtract_with_borrow_borrow_out: assert property (
    exec && op_in == OP_SUBTRACT_WITH_BORROW && size_in == SIZE_WORD
    |=> flags_r[FLAG_C] == $past({1'b0, dst_r} < 17'({1'b0, src_r} + flags_r[FLAG_C])))
    else $error("subtract with borrow gave a wrong carry");
  a_decimal_add_keeps_nv: assert property (
    exec && op_in == OP_DECIMAL_ADD
    |=> flags_r[FLAG_N] == $past(flags_r[FLAG_N]) && flags_r[FLAG_V] == $past(flags_r[FLAG_V])
        && dst_r[15:8] == $past(dst_r[15:8]))
    else $error("decimal add disturbed N, V or the upper byte");
  a_decimal_subtract_keeps_nv: assert property (
    exec && op_in == OP_DECIMAL_SUBTRACT && src_r[7:0] == dst_r[7:0] && !flags_r[FLAG_C]
    |=> flags_r[FLAG_Z] && !flags_r[FLAG_C]
        && $stable(flags_r[FLAG_N]) && $stable(flags_r[FLAG_V]))
    else $error("decimal subtract of equal values misbehaved");
  a_mul_clears_vc: assert property (
    exec && op_in == OP_UNSIGNED_MULTIPLY && size_in != SIZE_WORD
    |=> !flags_r[FLAG_V] && !flags_r[FLAG_C]
        && dst_r == $past(16'(dst_r[7:0]) * 16'(src_r[7:0])))
    else $error("byte multiply result or V, C wrong");
  a_div_done_flags: assert property (
    di.start |=> busy_r [*8] ##25 busy_r ##1 !busy_r && !flags_r[FLAG_C])
    else $error("divide did not finish on time with carry clear");
  a_div_zero_ovf: assert property (
    exec && op_in == OP_UNSIGNED_DIVIDE && div_zero
    |=> flags_r[FLAG_V] && !flags_r[FLAG_C] && !busy_r && $stable(dst_r))
    else $error("divide by zero not flagged as overflow");
  a_quick_word_add: assert property (
    exec && op_in == OP_QUICK_ADD && size_in == SIZE_WORD
    |=> dst_r == $past(16'(dst_r + quick_val(imm_in[1:0]))))
    else $error("quick add wrote a wrong value");
  a_addr_op_flags: assert property (
    exec && (op_in == OP_ADDRESS_ADD || op_in == OP_ADDRESS_SUBTRACT) |=> $stable(flags_r))
    else $error("address arithmetic changed a flag");
  a_cmp_no_write: assert property (
    exec && op_in == OP_COMPARE_OP
    |=> $stable(dst_r) && $stable(dst_hi_r)
        && flags_r[FLAG_Z] == $past(dst_r == src_r
                                    || (size_in != SIZE_WORD && dst_r[7:0] == src_r[7:0])))
    else $error("compare wrote the destination or set Z wrongly");
  a_movf_address: assert property (
    exec && op_in == OP_FRAME_RELATIVE_MOVE
    |=> addr_r == $past(16'(fp_r + ext_disp)) && !flags_r[FLAG_V] && $stable(flags_r[FLAG_C]))
    else $error("frame move address or flags wrong");
  a_byte_sign_bit: assert property (
    exec && op_in == OP_ADD_WITH_CARRY && size_in != SIZE_WORD
    |=> flags_r[FLAG_N] == dst_r[7] && dst_r[15:8] == $past(dst_r[15:8]))
    else $error("byte add took the wrong sign bit");

  c_add_with_carry_carry: cover property (exec && op_in == OP_ADD_WITH_CARRY ##1 flags_r[FLAG_C]);
  c_div_word:   cover property (di.start && size_in == SIZE_WORD ##[1:40] di.done);
  c_decimal_add_carry: cover property (exec && op_in == OP_DECIMAL_ADD ##1 flags_r[FLAG_C]);
  c_movf_back:  cover property (exec && op_in == OP_FRAME_RELATIVE_MOVE && imm_in[7]);
endmodule : cpu_arith_flag_datapath

// ==== bench/cpu_arith_flag_datapath_test.sv ====
// Self-checking bench for the arithmetic and flag datapath.
`timescale 1ns/10ps
module cpu_arith_flag_datapath_test;
  import alu_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [3:0]  flags;
  logic [15:0] frame_addr;
  logic        busy;
  logic        pend = 1'b0;
  logic [23:0] note_q[$];
  logic [23:0] note;
  logic [15:0] d_v;
  logic [15:0] s_v;
  logic [3:0]  f_v;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 27;

  cpu_arith_flag_datapath dut_u (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .flags(flags),
    .frame_addr(frame_addr), .busy(busy));

  // Clock of 5 ns period.
  always #2.5 clock = ~clock;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // One bus cycle; a read leaves its expected value as a note for the monitor.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en   <= w;
    rd_en   <= ~w;
    addr    <= a;
    wr_data <= d;
    if (!w) note_q.push_back({a, d});
  endtask : bus

  // Idle cycle; the address wanders randomly since no strobe qualifies it.
  task automatic idle;
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr  <= 8'($random(seed));
  endtask : idle

  task automatic run(input op_e op, input logic sz, input logic [7:0] imm,
                     input logic [15:0] d, input logic [15:0] s, input logic [3:0] f,
                     input logic [15:0] ed, input logic [3:0] ef);
    int n;
    bus(1'b1, OFF_DST, d);
    bus(1'b1, OFF_SRC, s);
    bus(1'b1, OFF_FLAGS, {12'h000, f});
    bus(1'b1, OFF_CMD, {imm, 3'h0, sz, op});
    idle();
    @(negedge clock);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk("busy", 16'h0000, {15'h0000, busy});
    bus(1'b0, OFF_DST, ed);
    bus(1'b0, OFF_FLAGS, {12'h000, ef});
    idle();
    @(negedge clock);
    chk("flags port", {12'h000, ef}, {12'h000, flags});
  endtask : run

  // Read data stand only in the cycle after the strobe, so they are taken at that negedge.
  always @(posedge clock) pend <= rd_en;
  always @(negedge clock) begin
    if (pend && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk($sformatf("reg %h", note[23:16]), note[15:0], rd_data);
    end
  end

  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, OFF_FLAGS, 16'h0000);
    bus(1'b0, 8'h20, 16'h0000);
    bus(1'b1, OFF_FP, 16'h1000);
    run(OP_ADD_WITH_CARRY, 1'b0, 8'h00, 16'h12FF, 16'h0001, 4'h1, 16'h1201, 4'h1);
    run(OP_ADD_WITH_CARRY, 1'b1, 8'h00, 16'h7FFF, 16'h0000, 4'h1, 16'h8000, 4'hA);
    run(OP_SUBTRACT_WITH_BORROW, 1'b1, 8'h00, 16'h0000, 16'h0000, 4'h1, 16'hFFFF, 4'h9);
    run(OP_DECIMAL_ADD, 1'b0, 8'h00, 16'h0099, 16'h0001, 4'hA, 16'h0000, 4'hF);
    run(OP_DECIMAL_SUBTRACT, 1'b0, 8'h00, 16'h0010, 16'h0001, 4'h9, 16'h0008, 4'h8);
    run(OP_UNSIGNED_MULTIPLY, 1'b0, 8'h00, 16'h00FF, 16'h00FF, 4'h3, 16'hFE01, 4'h8);
    run(OP_UNSIGNED_DIVIDE, 1'b0, 8'h00, 16'h0064, 16'h0007, 4'h1, 16'h020E, 4'h0);
    run(OP_QUICK_ADD, 1'b0, 8'h01, 16'h007F, 16'h0000, 4'h0, 16'h0081, 4'hA);
    run(OP_ADDRESS_ADD, 1'b0, 8'h00, 16'h00FF, 16'h0001, 4'h5, 16'h0100, 4'h5);
    run(OP_ADDRESS_SUBTRACT, 1'b1, 8'h00, 16'h0000, 16'h0001, 4'hA, 16'hFFFF, 4'hA);
    run(OP_COMPARE_OP, 1'b1, 8'h00, 16'h0005, 16'h0005, 4'hB, 16'h0005, 4'h4);
    run(OP_FRAME_RELATIVE_MOVE, 1'b1, 8'hFE, 16'h0000, 16'h8000, 4'h3, 16'h8000, 4'h9);
    chk("frame_addr", 16'h0FFE, frame_addr);
    bus(1'b0, OFF_ADDR, 16'h0FFE);
    // Word multiply and divide use the register pair; a zero divisor sets overflow, clears carry and keeps the register.
    run(OP_UNSIGNED_MULTIPLY, 1'b1, 8'h00, 16'hFFFF, 16'hFFFF, 4'h3, 16'h0001, 4'h8);
    bus(1'b0, OFF_DST_HI, 16'hFFFE);
    bus(1'b1, OFF_DST_HI, 16'h0001);
    run(OP_UNSIGNED_DIVIDE, 1'b1, 8'h00, 16'h0005, 16'h0100, 4'h1, 16'h0100, 4'h0);
    bus(1'b0, OFF_DST_HI, 16'h0005);
    run(OP_UNSIGNED_DIVIDE, 1'b0, 8'h00, 16'h1234, 16'h0100, 4'h9, 16'h1234, 4'hA);
    run(OP_DECIMAL_SUBTRACT, 1'b0, 8'h00, 16'h5542, 16'h0042, 4'h8, 16'h5500, 4'hC);
    run(OP_QUICK_ADD, 1'b1, 8'h03, 16'h0002, 16'h0000, 4'h0, 16'h0000, 4'h5);
    // An unused operation code must leave the destination and every flag alone.
    run(op_e'(4'hF), 1'b1, 8'h00, 16'h4321, 16'h0001, 4'h6, 16'h4321, 4'h6);
    // Random word operands: the sum lands whole and every flag survives.
    for (int i = 0; i < 6; i++) begin
      d_v = 16'($random(seed));
      s_v = 16'($random(seed));
      f_v = 4'($random(seed));
      run(OP_ADDRESS_ADD, 1'b1, 8'h00, d_v, s_v, f_v, 16'(d_v + s_v), f_v);
    end
    repeat (3) @(posedge clock);
    results();
  end
endmodule : cpu_arith_flag_datapath_test
